// File: core/usr_pkg.sv
// constants and carrier types for the 4-bit universal shift register
// ==========================================================
// Function
// RULE_01 - the register keeps four bits of state and always shows them on the parallel outputs.
// RULE_02 - shift right, shift left, parallel load and hold all update the four stages together.
// RULE_03 - mode select hi/lo: 00 holds, 10 shifts left, 01 shifts right, 11 loads in parallel.
// RULE_04 - in hold mode the stages keep their values whatever the data inputs do.
// RULE_05 - shift left moves stage 1..3 down into stage 0..2 and the left serial input into stage 3.
// RULE_06 - shift right puts the right serial input into stage 0 and moves stage 0..2 up.
// RULE_07 - parallel load copies the four parallel inputs into the four stages.
// RULE_08 - only the rising clock edge acts, using the inputs as they stood before it.
// RULE_09 - the active-low asynchronous clear forces all outputs low over every other input; the code clears only par_out and leaves cmd_ready alone.
// RULE_10 - the driving logic may change inputs at any time if they are stable around each edge.
// RULE_11 - the clock is edge sensitive: only its rising edge changes the stages.
// RULE_12 - after the clear is released, operation resumes from all zeros at the next rising edge.
package usr_pkg;
   localparam int WIDTH = 4;
   localparam int FIFO_DEPTH = 32;
   localparam logic [3:0] RESET_VALUE = 4'h0;
   localparam int SER_LEFT_STAGE = 3;
   localparam int SER_RIGHT_STAGE = 0;

   typedef enum logic [1:0] {
      MODE_HOLD,
      MODE_SHIFT_RIGHT,
      MODE_SHIFT_LEFT,
      MODE_LOAD
   } mode_t;

   // one request entering the register: mode, serial bits and parallel word
   typedef struct packed {
      logic mode_sel_hi;
      logic mode_sel_lo;
      logic ser_in_right;
      logic ser_in_left;
      logic [3:0] par_in;
   } cmd_t;

   localparam int CMD_W = $bits(cmd_t);
endpackage

// File: core/usr_fifo.sv
// parameterised valid/ready fifo held in flip-flops
`timescale 1ns/100ps
module usr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } fifo_state_t;

   fifo_state_t st_r;
   fifo_state_t st_nxt;
   logic push;
   logic pop;

   // ==========================================================
   // handshake
   assign in_ready = (st_r.count != (AW+1)'(DEPTH));
   assign out_valid = (st_r.count != '0);
   assign out_data = st_r.mem[st_r.rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // ==========================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wr_ptr] = in_data;
         st_nxt.wr_ptr = AW'(st_r.wr_ptr + 1'b1);
      end
      if (pop) begin
         st_nxt.rd_ptr = AW'(st_r.rd_ptr + 1'b1);
      end
      case ({push, pop})
         2'b10: st_nxt.count = (AW+1)'(st_r.count + 1'b1);
         2'b01: st_nxt.count = (AW+1)'(st_r.count - 1'b1);
         default: st_nxt.count = st_r.count;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end
endmodule // usr_fifo

// File: core/bidir_universal_shift_register.sv
// 4-bit universal shift register fed through a request fifo
`timescale 1ns/100ps
module bidir_universal_shift_register (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic clear_n,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic mode_sel_hi,
   input wire logic mode_sel_lo,
   input wire logic ser_in_right,
   input wire logic ser_in_left,
   input wire logic [3:0] par_in,
   input wire logic step_ready,
   output logic [3:0] par_out
);
   typedef struct packed {
      logic [3:0] stages;
   } top_state_t;

   top_state_t st_r;
   top_state_t st_nxt;
   // the release flops sit on the raw reset, so they live apart from the stage state
   logic [1:0] rst_sync_r;
   usr_pkg::cmd_t cmd_in;
   usr_pkg::cmd_t cmd_q;
   logic cmd_q_valid;
   logic step;
   logic rst_int_b;

   function automatic usr_pkg::mode_t decode_mode(input logic hi, input logic lo);
      case ({hi, lo}) // RULE_03
         2'b00: decode_mode = usr_pkg::MODE_HOLD;
         2'b10: decode_mode = usr_pkg::MODE_SHIFT_LEFT;
         2'b01: decode_mode = usr_pkg::MODE_SHIFT_RIGHT;
         default: decode_mode = usr_pkg::MODE_LOAD;
      endcase
   endfunction

   // ==========================================================
   // reset release
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_int_b = rst_sync_r[1];

   // ==========================================================
   // request buffer
   assign cmd_in = '{mode_sel_hi: mode_sel_hi, mode_sel_lo: mode_sel_lo,
                     ser_in_right: ser_in_right, ser_in_left: ser_in_left, par_in: par_in};

   usr_fifo #(.WIDTH(usr_pkg::CMD_W), .DEPTH(usr_pkg::FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst_b(rst_int_b),
      .clk_en(clk_en),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data(cmd_in),
      .out_valid(cmd_q_valid),
      .out_ready(step_ready && clear_n),
      .out_data(cmd_q)
   );

   // a step is one rising-edge transfer of the register
   assign step = cmd_q_valid && step_ready && clear_n; // RULE_11

   // ==========================================================
   // register stages
   always_comb begin
      st_nxt = st_r;
      if (step) begin
         case (decode_mode(cmd_q.mode_sel_hi, cmd_q.mode_sel_lo)) // RULE_02
            usr_pkg::MODE_HOLD: st_nxt.stages = st_r.stages; // RULE_04
            usr_pkg::MODE_SHIFT_LEFT:
               st_nxt.stages = {cmd_q.ser_in_left, st_r.stages[3:1]}; // RULE_05
            usr_pkg::MODE_SHIFT_RIGHT:
               st_nxt.stages = {st_r.stages[2:0], cmd_q.ser_in_right}; // RULE_06
            usr_pkg::MODE_LOAD: st_nxt.stages = cmd_q.par_in; // RULE_07
            default: st_nxt.stages = st_r.stages;
         endcase
      end
   end

   // clear_n acts asynchronously and beats everything else
   always_ff @(posedge clock or negedge rst_int_b or negedge clear_n) begin // RULE_08
      if (!rst_int_b || !clear_n) begin
         st_r.stages <= usr_pkg::RESET_VALUE; // RULE_09 RULE_12
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign par_out = st_r.stages; // RULE_01
endmodule // bidir_universal_shift_register

// File: verification/usr_chk.sv
// port assertions for the shift register
`timescale 1ns/100ps
module usr_chk (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic clear_n,
   input wire logic cmd_ready,
   input wire logic step_ready,
   input wire logic [3:0] par_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   a_clear_zero: assert property (!clear_n |-> par_out == 4'h0)
      else $error("clear left outputs set");
   a_rst_zero: assert property ($rose(rst_b) |-> par_out == 4'h0 ##1 par_out == 4'h0)
      else $error("outputs not zero after reset");
   a_rst_ready: assert property ($rose(rst_b) |-> ##2 cmd_ready)
      else $error("no ready after reset");
   a_step_hold: assert property (clear_n && !step_ready ##1 clear_n |-> $stable(par_out))
      else $error("outputs moved without a step");
   a_en_freeze: assert property (clear_n && !clk_en ##1 clear_n |-> $stable(par_out))
      else $error("outputs moved while disabled");
   a_full_stall: assert property ($past(rst_b, 3) && !cmd_ready && !step_ready |=> !cmd_ready)
      else $error("full queue drained while stalled");
   a_full_clear: assert property ($past(rst_b, 3) && !cmd_ready && !clear_n |=> !cmd_ready)
      else $error("full queue drained during clear");
   a_en_ready: assert property ($past(rst_b, 3) && !clk_en |=> $stable(cmd_ready))
      else $error("ready moved while disabled");
   cover property (!cmd_ready);
   cover property ($rose(clear_n));
   cover property (!clk_en && step_ready);
endmodule // usr_chk

bind bidir_universal_shift_register usr_chk u_chk (.clock(clock), .rst_b(rst_b),
   .clk_en(clk_en), .clear_n(clear_n), .cmd_ready(cmd_ready), .step_ready(step_ready),
   .par_out(par_out));

// File: verification/usr_step_gen.sv
// downstream logic that grants or stalls each step
`timescale 1ns/100ps
module usr_step_gen (
   input wire logic clock,
   input wire logic stall,
   output logic step_ready
);
   logic [31:0] seed = 32'hF54F;
   initial step_ready = 1'b0;
   always @(negedge clock) step_ready <= !stall && ($random(seed) % 3 != 0);
endmodule // usr_step_gen

// File: verification/bidir_universal_shift_register_tb_top.sv
// self-checking bench for the shift register
`timescale 1ns/100ps
module bidir_universal_shift_register_tb_top;
   logic clock = 1'b0, rst_b, clk_en, clear_n, cmd_valid, cmd_ready, step_ready, stall;
   logic [3:0] par_out, model;
   logic [31:0] seed = 32'hF54F;
   usr_pkg::cmd_t c, p, cq[$];
   int err_count, total_checks, avail, n, i;
   bidir_universal_shift_register u_dut (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
      .clear_n(clear_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .mode_sel_hi(c.mode_sel_hi), .mode_sel_lo(c.mode_sel_lo), .ser_in_right(c.ser_in_right),
      .ser_in_left(c.ser_in_left), .par_in(c.par_in), .step_ready(step_ready), .par_out(par_out));
   usr_step_gen u_step (.clock(clock), .stall(stall), .step_ready(step_ready));
   initial forever #4 clock = ~clock;
   // ==========
   // checking
   task automatic chk(string s, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (e !== g) begin
         err_count++;
         $display("mismatch %s exp %h got %h", s, e, g);
      end
   endtask
   task end_sim();
      if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // a pop happens only for notes already in the queue before this edge
   always @(posedge clock) begin
      if (!clear_n) model = 4'h0;
      else if (avail > 0 && step_ready && clk_en) begin
         p = cq.pop_front();
         case ({p.mode_sel_hi, p.mode_sel_lo})
            2'b10: model = {p.ser_in_left, model[3:1]};
            2'b01: model = {model[2:0], p.ser_in_right};
            2'b11: model = p.par_in;
            default: ;
         endcase
      end
      avail = cq.size();
   end
   always @(negedge clock) if (rst_b) chk("par_out", {4'h0, model}, {4'h0, par_out});
   // ==========
   // stimulus
   task send(input usr_pkg::cmd_t v);
      c = v;
      cmd_valid = 1'b1;
      for (n = 0; n < 200; n++) begin
         clk_en = $random(seed) % 5 != 0;
         if (cmd_ready && clk_en) begin
            cq.push_back(v);
            @(negedge clock);
            return;
         end
         @(negedge clock);
      end
      err_count++;
      end_sim();
   endtask
   task drain();
      for (n = 0; n < 400 && cq.size() > 0; n++) @(negedge clock);
      if (cq.size() > 0) begin
         err_count++;
         end_sim();
      end
   endtask
   initial begin
      {rst_b, clk_en, clear_n, cmd_valid, stall} = 5'b01100;
      c = '0;
      model = 4'h0;
      repeat (8) @(negedge clock);
      rst_b = 1'b1;
      repeat (3) @(negedge clock);
      for (i = 0; i < 80; i++) begin
         if (i == 40) begin
            cmd_valid = 1'b0;
            clear_n <= 1'b0;
            #1 chk("clear", 8'h00, {4'h0, par_out});
            @(negedge clock);
            clear_n <= 1'b1;
         end
         send({i[1:0], 6'($random(seed))});
      end
      cmd_valid = 1'b0;
      drain();
      stall = 1'b1;
      repeat (2) @(negedge clock);
      for (i = 0; i < 40 && cmd_ready; i++) send({2'b11, 6'($random(seed))});
      cmd_valid = 1'b0;
      chk("fill", 8'(usr_pkg::FIFO_DEPTH), 8'(i));
      // clear while full and granted: nothing may drain, the queue stays full
      stall = 1'b0;
      clear_n <= 1'b0;
      repeat (2) @(negedge clock);
      clear_n <= 1'b1;
      chk("full_kept", 8'h00, {7'h00, cmd_ready});
      drain();
      end_sim();
   end
endmodule // bidir_universal_shift_register_tb_top
